// *** include/rscp_pkg.sv ***
package rscp_pkg;
   // header byte layout
   localparam int HDR_RNW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam int INDEX_W = 6;
   // index map
   localparam logic [5:0] IDX_CFG_LAST = 6'h2e;
   localparam logic [5:0] IDX_STAT_FIRST = 6'h30;
   localparam logic [5:0] IDX_STAT_LAST = 6'h3d;
   localparam logic [5:0] IDX_PAYLOAD = 6'h3f;
   localparam logic [5:0] IDX_FULL_RESET = 6'h30;
   // status byte fields, buffer depth, config register count and default
   localparam int STAT_RDY_BIT = 7;
   localparam logic [3:0] CNT_SAT = 4'hf;
   localparam int BUF_DEPTH = 64;
   localparam int NUM_CFG = 47;
   localparam logic [7:0] CFG_RESET_VAL = 8'h00;

   typedef enum logic [1:0] {RSCP_IDLE, RSCP_HDR, RSCP_DATA} rscp_phase_type;

   // decoded header carried as one unit
   typedef struct packed {
      logic rnw;
      logic burst;
      logic [5:0] index;
   } rscp_hdr_type;

   // payload word handed toward or from the radio
   typedef struct packed {
      logic [7:0] data;
   } rscp_word_type;
endpackage : rscp_pkg

// *** design/rscp_port.sv ***
`timescale 1ns/10ps
// Overview of operation
// R1: serial bytes move most significant bit first both directions
// R2: first byte holds read flag, burst flag and six-bit index
// R3: master holds chip select low through every transfer
// R4: select released mid-byte abandons the byte with no effect
// R5: master waits for serial output low before shifting header
// R6: serial output goes low after select only when oscillator runs
// R7: outside sleep and oscillator-off, serial output falls at once
// R8: master keeps serial clock under the documented rate limits
// R9: blind master waits 150 us from select to first clock rise
// R10: input sampled on rising clock edge; master changes after falling
// R11: one port reaches config registers and 64-byte receive, transmit buffers
// R12: any reset loads every config register with its default
// R13: master rewrites non-default registers after each reset
// R14: full-reset strobe restores known state after poor power-up
// R15: status byte returned: not-ready, main state, buffer count
// R16: count is readable receive bytes or free transmit bytes, saturating at 15
// R17: burst index counter increments after every eight clock pulses
// R18: indices 0x30-0x3d select status read with burst, strobe without
// R19: serial output changes on falling clock edge
module rscp_port
   import rscp_pkg::*;
(
   input wire logic sys_clk, // 50 MHz
   input wire logic rstn, // async, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic chip_select_low, // pin, async
   input wire logic serial_clk, // pin, async
   input wire logic serial_in, // pin, async
   output logic serial_out, // pin
   output logic serial_out_oe, // high while driving
   input wire logic osc_running, // crystal stable
   input wire logic oscillator_off_state, // sleep or oscillator-off
   input wire logic [2:0] main_state, // radio state code
   input wire logic [6:0] rx_level, // receive buffer bytes held
   input wire logic [6:0] tx_level, // transmit buffer bytes held
   input wire logic [7:0] stat_rdata, // status register value at index
   output logic [5:0] stat_index, // status register selector
   output logic strobe_valid, // one-cycle command strobe
   output logic [5:0] strobe_index, // strobe index
   output logic full_reset_strobe, // one-cycle soft reset pulse
   output logic tx_valid, // write word toward transmit buffer
   input wire logic tx_ready, // transmit buffer accepts
   output rscp_word_type tx_word, // write data
   input wire logic rx_valid, // receive buffer word ready
   output logic rx_ready, // pop receive buffer
   input wire rscp_word_type rx_word, // receive data
   output logic [NUM_CFG*8-1:0] cfg_flat // config registers
);
   // two-flop synchronisers for clock and data pins; chip select passes through four flops
   logic [1:0] cs_s1_ff, cs_s2_ff;
   logic sck_s1_ff, sck_s2_ff, sck_d_ff, si_s1_ff, si_s2_ff;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cs_s1_ff <= 2'h3;
         cs_s2_ff <= 2'h3;
         sck_s1_ff <= 1'b0;
         sck_s2_ff <= 1'b0;
         sck_d_ff <= 1'b0;
         si_s1_ff <= 1'b0;
         si_s2_ff <= 1'b0;
      end else if (clk_en) begin
         cs_s1_ff <= {cs_s1_ff[0], chip_select_low};
         cs_s2_ff <= {cs_s2_ff[0], cs_s1_ff[1]};
         sck_s1_ff <= serial_clk;
         sck_s2_ff <= sck_s1_ff;
         sck_d_ff <= sck_s2_ff;
         si_s1_ff <= serial_in;
         si_s2_ff <= si_s1_ff;
      end
   end
   wire cs_act = !cs_s2_ff[1];
   wire sck_rise = sck_s2_ff && !sck_d_ff;
   wire sck_fall = !sck_s2_ff && sck_d_ff;

   // frame state
   rscp_phase_type phase_ff, nxt_phase;
   rscp_hdr_type hdr_ff;
   logic [5:0] addr_ff;
   logic [7:0] shin_ff, shout_ff;
   logic [2:0] bitcnt_ff;
   logic [7:0] cfg_ff [NUM_CFG];
   logic so_ff;

   // byte completes on eighth rising edge; shift MSB first
   wire byte_done = sck_rise && (bitcnt_ff == 3'h7); // [R1] [R10]
   wire [7:0] byte_in = {shin_ff[6:0], si_s2_ff}; // [R1]
   wire rdy_ok = osc_running && !oscillator_off_state; // [R6] [R7]
   wire rscp_hdr_type hdr_new = byte_in; // [R2]
   wire in_stat = (hdr_new.index >= IDX_STAT_FIRST) && (hdr_new.index <= IDX_STAT_LAST);
   wire is_strobe = in_stat && !hdr_new.burst; // [R18]
   wire is_stat = in_stat && hdr_new.burst;
   wire is_cfg_addr = addr_ff <= IDX_CFG_LAST;
   wire is_pay = addr_ff == IDX_PAYLOAD;
   // count field: readable rx on reads, free tx on writes, saturated
   wire [6:0] tx_free = 7'(BUF_DEPTH) - tx_level; // [R11]
   // the read flag is the first header bit, so the count follows it once it lands
   wire first_rise = (phase_ff == RSCP_HDR) && sck_rise && (bitcnt_ff == 3'h0) && cs_act;
   wire hdr_end = (phase_ff == RSCP_HDR) && byte_done;
   wire cur_rnw = first_rise ? si_s2_ff : hdr_end ? hdr_new.rnw : hdr_ff.rnw; // [R16]
   wire [6:0] cnt_raw = cur_rnw ? rx_level : tx_free; // [R16]
   wire [3:0] cnt_sat = (cnt_raw > 7'(CNT_SAT)) ? CNT_SAT : cnt_raw[3:0]; // [R16]
   wire [7:0] status_byte = {!rdy_ok, main_state, cnt_sat}; // [R15]
   // data phase byte effects: writes and pops fire on completed bytes only
   wire data_done = (phase_ff == RSCP_DATA) && byte_done && cs_act; // [R4]
   wire wr_cfg = data_done && !hdr_ff.rnw && is_cfg_addr;
   wire hdr_done = (phase_ff == RSCP_HDR) && byte_done && cs_act;

   // phase sequencing; select high drops back to idle at once
   always_comb begin
      nxt_phase = phase_ff;
      unique case (phase_ff)
         RSCP_IDLE: if (cs_act && rdy_ok) nxt_phase = RSCP_HDR; // [R5]
         RSCP_HDR: if (hdr_done && !is_strobe) nxt_phase = RSCP_DATA;
         RSCP_DATA: nxt_phase = RSCP_DATA;
      endcase
      if (!cs_act) nxt_phase = RSCP_IDLE; // [R4]
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase_ff <= RSCP_IDLE;
         bitcnt_ff <= 3'h0;
         shin_ff <= 8'h00;
         hdr_ff <= '0;
         addr_ff <= 6'h00;
      end else if (clk_en) begin
         phase_ff <= nxt_phase;
         if (!cs_act || phase_ff == RSCP_IDLE) begin
            bitcnt_ff <= 3'h0; // partial byte dropped
         end else if (sck_rise) begin
            bitcnt_ff <= bitcnt_ff + 3'h1;
            shin_ff <= byte_in; // [R10]
         end
         if (hdr_done) begin
            hdr_ff <= hdr_new;
            addr_ff <= hdr_new.index; // [R17]
         end else if (data_done && hdr_ff.burst) begin
            addr_ff <= addr_ff + 6'h1; // [R17]
         end
      end
   end

   // config registers: defaults on reset and on full-reset strobe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_CFG; i++) cfg_ff[i] <= CFG_RESET_VAL; // [R12]
      end else if (clk_en) begin
         if (full_reset_strobe) begin
            for (int i = 0; i < NUM_CFG; i++) cfg_ff[i] <= CFG_RESET_VAL; // [R14]
         end else if (wr_cfg) begin
            cfg_ff[addr_ff] <= byte_in; // [R11]
         end
      end
   end
   for (genvar g = 0; g < NUM_CFG; g++) begin : g_flat
      assign cfg_flat[g*8 +: 8] = cfg_ff[g];
   end

   // read byte source selected at header end or after each burst byte
   wire [5:0] nxt_addr = hdr_done ? hdr_new.index : addr_ff + 6'h1;
   wire nxt_in_cfg = nxt_addr <= IDX_CFG_LAST;
   wire [7:0] cfg_pick = nxt_in_cfg ? cfg_ff[nxt_addr] : 8'h00;
   wire nxt_pay = nxt_addr == IDX_PAYLOAD;
   wire [7:0] nxt_rd = (hdr_done && is_stat) ? stat_rdata : // [R18]
                       nxt_pay ? rx_word.data : cfg_pick;
   // strobes carry no data, so a read-flagged strobe still returns status
   wire rd_load = (hdr_done && hdr_new.rnw && !is_strobe) ||
                  (data_done && hdr_ff.rnw && hdr_ff.burst);
   assign stat_index = hdr_new.index;
   // pop receive buffer when its byte is loaded for shifting out
   assign rx_ready = clk_en && rd_load && nxt_pay && rx_valid; // [R11]

   // strobes: one-cycle pulses from flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         strobe_valid <= 1'b0;
         strobe_index <= 6'h00;
         full_reset_strobe <= 1'b0;
      end else if (clk_en) begin
         strobe_valid <= hdr_done && is_strobe; // [R18]
         full_reset_strobe <= hdr_done && is_strobe && (hdr_new.index == IDX_FULL_RESET); // [R14]
         if (hdr_done) strobe_index <= hdr_new.index;
      end
   end

   // two-entry transmit buffer: a stalled radio side holds up to two written bytes
   logic [7:0] tx_spare_ff;
   logic tx_spare_vld_ff;
   wire tx_push = data_done && !hdr_ff.rnw && is_pay; // [R11]
   wire tx_pop = tx_valid && tx_ready;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_valid <= 1'b0;
         tx_word <= '0;
         tx_spare_ff <= 8'h00;
         tx_spare_vld_ff <= 1'b0;
      end else if (clk_en) begin
         if (tx_pop) begin
            // head leaves: spare moves up, a new byte fills in behind it
            tx_valid <= tx_spare_vld_ff || tx_push;
            tx_word.data <= tx_spare_vld_ff ? tx_spare_ff : byte_in;
            tx_spare_vld_ff <= tx_spare_vld_ff && tx_push;
            if (tx_spare_vld_ff && tx_push) tx_spare_ff <= byte_in;
         end else if (tx_push && !tx_valid) begin
            tx_valid <= 1'b1; // [R11]
            tx_word.data <= byte_in;
         end else if (tx_push && !tx_spare_vld_ff) begin
            tx_spare_vld_ff <= 1'b1; // a third byte while both are full is lost
            tx_spare_ff <= byte_in;
         end
      end
   end

   // output shifter: read data after a read header and after each burst read byte, status otherwise
   wire first_load = (phase_ff == RSCP_IDLE) && (nxt_phase == RSCP_HDR);
   wire out_rd = (phase_ff == RSCP_DATA) && hdr_ff.rnw;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shout_ff <= 8'hff;
         so_ff <= 1'b1;
      end else if (clk_en) begin
         if (!cs_act) begin
            shout_ff <= 8'hff;
            so_ff <= 1'b1;
         end else if (first_load) begin
            // top bit goes out now, so the shifter keeps only the other seven
            shout_ff <= {status_byte[6:0], 1'b0};
            so_ff <= 1'b0; // [R6] [R7]
         end else if (phase_ff == RSCP_IDLE) begin
            so_ff <= 1'b1; // [R6]
         end else if (first_rise) begin
            shout_ff <= {status_byte[6:0], 1'b0}; // [R16]
         end else if (byte_done) begin
            shout_ff <= rd_load ? nxt_rd : status_byte; // [R15]
         end else if (sck_fall) begin
            so_ff <= shout_ff[7]; // [R19] [R1]
            shout_ff <= {shout_ff[6:0], 1'b0};
         end
      end
   end
   assign serial_out = so_ff;
   assign serial_out_oe = cs_act;

   // status byte top bit must be the not-ready flag when it is shifted
   osc_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
      (phase_ff == RSCP_IDLE && cs_act && !rdy_ok) |=> serial_out)
      else $error("serial output fell before oscillator ready");
   fast_low_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
      (clk_en && phase_ff == RSCP_IDLE && cs_act && rdy_ok) |=> !serial_out)
      else $error("serial output not pulled low at once");
   cancel_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R4]
      (clk_en && !cs_act) |=> !(strobe_valid && $rose(strobe_valid)) && phase_ff == RSCP_IDLE)
      else $error("released select did not abandon frame");
   burst_inc_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R17]
      (clk_en && data_done && hdr_ff.burst) |=> addr_ff == $past(addr_ff) + 6'h1)
      else $error("burst address did not advance");
   cnt_sat_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R16]
      (cnt_raw >= 7'h0f) |-> cnt_sat == 4'hf)
      else $error("count field not saturated");
   strobe_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R18]
      (clk_en && hdr_done && in_stat && hdr_new.burst) |=> !strobe_valid)
      else $error("status read issued a strobe");
   reset_def_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R14]
      (clk_en && full_reset_strobe) |=> cfg_flat == {NUM_CFG{CFG_RESET_VAL}})
      else $error("full reset left config dirty");
   rdy_bit_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
      status_byte[STAT_RDY_BIT] == !rdy_ok)
      else $error("ready flag wrong in status");
   so_fall_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R19]
      (clk_en && cs_act && phase_ff != RSCP_IDLE && !sck_fall) |=> $stable(serial_out))
      else $error("serial output moved off a falling clock edge");
   strobe_idx_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
      (clk_en && hdr_done && is_strobe)
      |=> strobe_valid && strobe_index == $past(hdr_new.index))
      else $error("strobe index not taken from header");
   tx_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
      (clk_en && tx_valid && !tx_ready) |=> tx_valid && $stable(tx_word))
      else $error("stalled transmit byte changed or dropped");
endmodule : rscp_port

// *** dv/rscp_master.sv ***
`timescale 1ns/10ps
// bus master stand-in; the link clock idles low and stands still between frames
module rscp_master (
   output logic chip_select_low, // frame select
   output logic serial_clk, // link clock, 160 ns period
   output logic serial_in, // data toward the port
   input wire logic serial_out // data from the port
);
   logic timed_out = 1'b0; // sticky: ready level never came
   initial begin
      chip_select_low = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end
   // select, then hold the clock off until the ready low level
   task automatic open_frame(input int limit);
      chip_select_low = 1'b0;
      for (int i = 0; i < limit && serial_out !== 1'b0; i++) #20;
      if (serial_out !== 1'b0) timed_out = 1'b1;
   endtask : open_frame
   // a master that ignores the ready level waits out oscillator start
   task automatic open_blind;
      chip_select_low = 1'b0;
      #150000;
   endtask : open_blind
   // msb first; change after fall, sample on rise; 6.25 MHz clock
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         serial_in = tx[i];
         #80 serial_clk = 1'b1;
         rx[i] = serial_out;
         #80 serial_clk = 1'b0;
      end
   endtask : shift
   // released input flips so a stale bit cannot pass for data
   task automatic close_frame;
      #40 chip_select_low = 1'b1;
      serial_in = ~serial_in;
      #200;
   endtask : close_frame
endmodule : rscp_master

// *** dv/rscp_port_test.sv ***
`timescale 1ns/10ps
module rscp_port_test
   import rscp_pkg::*;
;
   logic sys_clk, rstn, chip_select_low, serial_clk, serial_in, serial_out, serial_out_oe;
   logic osc_running, oscillator_off_state, strobe_valid, full_reset_strobe, clk_en;
   logic tx_valid, tx_ready, rx_valid, rx_ready;
   logic [2:0] main_state;
   logic [6:0] rx_level, tx_level;
   logic [7:0] stat_rdata, st;
   logic [7:0] wr[3], rd[3], tx_got[2], rx_mem[2];
   logic [5:0] stat_index, strobe_index, last_strobe;
   rscp_word_type tx_word, rx_word;
   logic [NUM_CFG*8-1:0] cfg_flat;
   int fails, checks_done, n_strobe, n_full, n_tx, rx_pops, rx_ptr;
   // status registers echo their index so a wrong selector shows
   assign stat_rdata = {2'b10, stat_index};
   assign rx_valid = rx_ptr < 2;
   assign rx_word = rx_mem[rx_ptr[0]];
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   rscp_port uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
      .chip_select_low(chip_select_low), .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe), .osc_running(osc_running),
      .oscillator_off_state(oscillator_off_state), .main_state(main_state),
      .rx_level(rx_level), .tx_level(tx_level), .stat_rdata(stat_rdata),
      .stat_index(stat_index), .strobe_valid(strobe_valid), .strobe_index(strobe_index),
      .full_reset_strobe(full_reset_strobe), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_word(tx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
      .cfg_flat(cfg_flat));
   // released data line floats to its pull-up level
   wire so_line = serial_out_oe ? serial_out : 1'b1;
   rscp_master m (.chip_select_low(chip_select_low), .serial_clk(serial_clk),
      .serial_in(serial_in), .serial_out(so_line));
   // radio-side bookkeeping; pre-edge values are the ones the design takes
   always @(posedge sys_clk) begin
      if (strobe_valid === 1'b1) begin
         n_strobe++;
         last_strobe = strobe_index;
      end
      if (full_reset_strobe === 1'b1) n_full++;
      if (tx_valid === 1'b1 && tx_ready) begin
         tx_got[n_tx[0]] = tx_word.data;
         n_tx++;
      end
      if (rx_valid && rx_ready === 1'b1) rx_pops++;
   end
   always @(negedge sys_clk) rx_ptr <= rx_pops;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // expected status byte; count saturates at fifteen
   function automatic logic [7:0] stat(input logic rnw);
      logic [6:0] c;
      c = rnw ? rx_level : 7'h40 - tx_level;
      return {1'b0, main_state, (c > 7'h0f) ? 4'hf : c[3:0]};
   endfunction : stat
   // one framed access; nb bits of each data byte, fewer to cut it short
   task automatic frame(input logic [7:0] hdr, input int n, input int nb);
      @(negedge sys_clk);
      #3 m.open_frame(10);
      m.shift(hdr, 8, st);
      for (int i = 0; i < n; i++) m.shift(wr[i], nb, rd[i]);
      m.close_frame();
   endtask : frame
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // watchdog set well above the run time of the whole test
   initial begin
      #1500000;
      fails++;
      print_verdict();
   end
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      osc_running = 1'b0;
      oscillator_off_state = 1'b1;
      main_state = 3'h5;
      rx_level = 7'h14;
      tx_level = 7'h3c;
      tx_ready = 1'b0;
      rx_mem = '{8'h9c, 8'h9d};
      wr = '{8'ha5, 8'h5a, 8'h3c};
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      @(negedge sys_clk);
      check(cfg_flat[5*8+:8], CFG_RESET_VAL);
      #3 m.open_frame(10);
      check({7'h00, m.timed_out}, 8'h01);
      check({7'h00, serial_out_oe}, 8'h01);
      @(negedge sys_clk);
      osc_running = 1'b1;
      oscillator_off_state = 1'b0;
      m.timed_out = 1'b0;
      #3 m.open_frame(10);
      check({7'h00, m.timed_out}, 8'h00);
      m.close_frame();
      $display("test ready done");
      frame(8'h05, 1, 8);
      check(st, stat(1'b0));
      check(rd[0], stat(1'b0));
      check(cfg_flat[5*8+:8], 8'ha5);
      frame(8'h85, 1, 8);
      check(st, stat(1'b1));
      check(rd[0], 8'ha5);
      frame(8'h4a, 3, 8);
      frame(8'hca, 3, 8);
      for (int i = 0; i < 3; i++) begin
         check(cfg_flat[(10+i)*8+:8], wr[i]);
         check(rd[i], wr[i]);
      end
      frame(8'h06, 1, 5);
      check(cfg_flat[6*8+:8], CFG_RESET_VAL);
      $display("test registers done");
      frame(8'hf5, 1, 8);
      check(rd[0], 8'hb5);
      for (int i = 8'h31; i <= 8'h3d; i++) begin
         frame(i[7:0], 0, 8);
         check({2'b00, last_strobe}, i[7:0]);
      end
      check(n_strobe[7:0], 8'h0d);
      frame(8'h30, 0, 8);
      check(n_full[7:0], 8'h01);
      check(cfg_flat[10*8+:8], CFG_RESET_VAL);
      $display("test strobes done");
      wr[0] = 8'hc1;
      frame(8'h3f, 1, 8);
      wr[0] = 8'hc2;
      frame(8'h3f, 1, 8);
      check(n_tx[7:0], 8'h00);
      @(negedge sys_clk);
      tx_ready = 1'b1;
      for (int i = 0; i < 40 && n_tx < 2; i++) @(negedge sys_clk);
      if (n_tx < 2) begin
         fails++;
         print_verdict();
      end
      check(tx_got[0], 8'hc1);
      check(tx_got[1], 8'hc2);
      frame(8'hbf, 1, 8);
      check(rd[0], 8'h9c);
      frame(8'hbf, 1, 8);
      check(rd[0], 8'h9d);
      check({7'h00, m.timed_out}, 8'h00);
      $display("test payload done");
      // a frozen port must not answer select; it answers once enabled again
      @(negedge sys_clk);
      clk_en = 1'b0;
      #3 m.open_frame(10);
      check({7'h00, m.timed_out}, 8'h01);
      @(negedge sys_clk);
      clk_en = 1'b1;
      m.timed_out = 1'b0;
      #3 m.open_frame(10);
      check({7'h00, m.timed_out}, 8'h00);
      m.close_frame();
      $display("test enable done");
      m.open_blind();
      m.shift(8'h07, 8, st);
      m.shift(8'h3c, 8, rd[0]);
      m.close_frame();
      check(cfg_flat[7*8+:8], 8'h3c);
      $display("test blind done");
      print_verdict();
   end
endmodule : rscp_port_test
